// [hw/psc_top.sv]
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Exactly one of normal, exception, halted
// - Execution, fetch, store, coprocessor count normal
// - Exception ends when handler starts executing
// - Interrupt, trace, trap, fault enter exception
// - Fault during exception processing halts
// - Only external reset leaves halted
// - Stop: normal, no bus cycles, not halted
// - Supervisor bit picks privilege and stack
// - Function code marks supervisor or user
// - Supervisor runs all, supervisor space codes
// - Master bit set selects master stack
// - Master bit clear selects interrupt stack
// - Reset gives supervisor interrupt mode
// - Master bit never affects privilege checks
// - Only status ops, return and interrupt entry change master
// - Interrupt entry saves then clears master
// - Exception cycles supervisor, active supervisor stack
// - User privileged attempt traps to supervisor
// - Supervisor clear: user references, user stack
// - Entry pushes status word then sets supervisor
// - Three-bit codes 1,2,5,6,7 only
module psc_top (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic op_valid,
	input wire logic [2:0] op_kind,
	input wire logic [15:0] op_data,
	input wire logic irq_ack,
	input wire logic trace_event,
	input wire logic trap_event,
	input wire logic other_exception,
	input wire logic bus_error,
	input wire logic address_error,
	input wire logic stack_done,
	input wire logic vector_done,
	input wire logic handler_start,
	input wire logic bus_req,
	input wire logic bus_program,
	input wire logic bus_cpu_space,
	input wire logic sp_wr,
	input wire logic [31:0] sp_wdata,
	output logic [15:0] status_word,
	output logic [4:0] proc_state,
	output logic stopped,
	output logic [2:0] access_space_code,
	output logic access_valid,
	output logic [1:0] sp_select,
	output logic [31:0] active_stack_pointer,
	output logic push_valid,
	output logic [15:0] push_status_word,
	output logic priv_trap
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	psc_pkg::psc_regs_s st_r;
	psc_pkg::psc_regs_s st_nxt;
	logic sup;
	logic master;
	logic in_exc;
	logic is_normal;
	logic fault;
	logic op_priv;
	logic user_violation;
	logic exc_event;
	logic op_ok;

	assign sup = st_r.sw[psc_pkg::S_BIT];
	assign master = st_r.sw[psc_pkg::M_BIT];
	assign is_normal = (st_r.state == psc_pkg::PSC_ST_NORMAL);
	assign in_exc = (st_r.state == psc_pkg::PSC_ST_STACK) || (st_r.state == psc_pkg::PSC_ST_VECTOR) ||
		(st_r.state == psc_pkg::PSC_ST_FILL);
	assign fault = bus_error || address_error;
	// Privilege test reads only the supervisor bit, master mode is not a factor
	assign op_priv = (op_kind != psc_pkg::OP_PLAIN);
	assign user_violation = op_valid && op_priv && !sup && is_normal && !st_r.stopped;
	assign exc_event = irq_ack || trace_event || trap_event || other_exception || fault || user_violation;
	// An exception in the same cycle wins over the operation, which is retried after return
	assign op_ok = op_valid && is_normal && !st_r.stopped && !exc_event && (sup || !op_priv);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.push_valid = 1'b0;
		st_nxt.priv_trap = 1'b0;
		st_nxt.fc_valid = 1'b0;
		st_nxt.rdata = 32'h0;
		unique case (st_r.state)
			psc_pkg::PSC_ST_NORMAL: begin
				if (exc_event) begin
					// Push the old word first, then force supervisor
					st_nxt.state = psc_pkg::PSC_ST_STACK;
					st_nxt.stopped = 1'b0;
					st_nxt.saved_sw = st_r.sw;
					st_nxt.push_valid = 1'b1;
					st_nxt.sw[psc_pkg::S_BIT] = 1'b1;
					st_nxt.priv_trap = user_violation;
					if (irq_ack) begin
						st_nxt.sw[psc_pkg::M_BIT] = 1'b0;
					end
				end else if (op_ok) begin
					// Apart from interrupt entry above, the master bit changes only through these operations
					unique case (op_kind)
						psc_pkg::OP_MOVE: begin
							st_nxt.sw = op_data;
						end
						psc_pkg::OP_AND: begin
							st_nxt.sw = st_r.sw & op_data;
						end
						psc_pkg::OP_XOR: begin
							st_nxt.sw = st_r.sw ^ op_data;
						end
						psc_pkg::OP_OR: begin
							st_nxt.sw = st_r.sw | op_data;
						end
						psc_pkg::OP_RETURN: begin
							st_nxt.sw = op_data;
						end
						psc_pkg::OP_STOP: begin
							st_nxt.stopped = 1'b1;
						end
						psc_pkg::OP_PRIV: begin
							st_nxt.stopped = st_r.stopped;
						end
						psc_pkg::OP_PLAIN: begin
							st_nxt.stopped = st_r.stopped;
						end
					endcase
				end
			end
			psc_pkg::PSC_ST_STACK: begin
				if (fault) begin
					st_nxt.state = psc_pkg::PSC_ST_HALT;
				end else if (stack_done) begin
					st_nxt.state = psc_pkg::PSC_ST_VECTOR;
				end
			end
			psc_pkg::PSC_ST_VECTOR: begin
				if (fault) begin
					st_nxt.state = psc_pkg::PSC_ST_HALT;
				end else if (vector_done) begin
					st_nxt.state = psc_pkg::PSC_ST_FILL;
				end
			end
			psc_pkg::PSC_ST_FILL: begin
				if (fault) begin
					st_nxt.state = psc_pkg::PSC_ST_HALT;
				end else if (handler_start) begin
					st_nxt.state = psc_pkg::PSC_ST_NORMAL;
				end
			end
			psc_pkg::PSC_ST_HALT: begin
				// Nothing but reset leaves here
				st_nxt.state = psc_pkg::PSC_ST_HALT;
			end
		endcase

		// Bus classification; stopped and halted run no cycles
		if (bus_req && !st_r.stopped && (st_r.state != psc_pkg::PSC_ST_HALT)) begin
			st_nxt.fc_valid = 1'b1;
			if (bus_cpu_space) begin
				st_nxt.fc = psc_pkg::FC_CPU_SPACE;
			end else if (sup || in_exc) begin
				if (bus_program) begin
					st_nxt.fc = psc_pkg::FC_SUPER_PROG;
				end else begin
					st_nxt.fc = psc_pkg::FC_SUPER_DATA;
				end
			end else begin
				if (bus_program) begin
					st_nxt.fc = psc_pkg::FC_USER_PROG;
				end else begin
					st_nxt.fc = psc_pkg::FC_USER_DATA;
				end
			end
		end

		// Stack pointer selection
		if (!sup && !in_exc) begin
			st_nxt.sp_sel = psc_pkg::SEL_USER;
		end else if (master) begin
			st_nxt.sp_sel = psc_pkg::SEL_MASTER;
		end else begin
			st_nxt.sp_sel = psc_pkg::SEL_INTERRUPT;
		end

		// Software loads pointers on task switch; the core's own update wins a collision
		// Status and state offsets fall through, so software can never move the master bit
		if (reg_wr) begin
			unique case (reg_addr)
				psc_pkg::OFS_USP: begin
					st_nxt.user_stack_pointer = reg_wdata;
				end
				psc_pkg::OFS_ISP: begin
					st_nxt.interrupt_stack_pointer = reg_wdata;
				end
				psc_pkg::OFS_MSP: begin
					st_nxt.master_stack_pointer = reg_wdata;
				end
				default: begin
					st_nxt.rdata = 32'h0;
				end
			endcase
		end
		if (sp_wr) begin
			unique case (st_r.sp_sel)
				psc_pkg::SEL_USER: begin
					st_nxt.user_stack_pointer = sp_wdata;
				end
				psc_pkg::SEL_MASTER: begin
					st_nxt.master_stack_pointer = sp_wdata;
				end
				default: begin
					st_nxt.interrupt_stack_pointer = sp_wdata;
				end
			endcase
		end

		unique case (st_r.sp_sel)
			psc_pkg::SEL_USER: begin
				st_nxt.active_sp = st_r.user_stack_pointer;
			end
			psc_pkg::SEL_MASTER: begin
				st_nxt.active_sp = st_r.master_stack_pointer;
			end
			default: begin
				st_nxt.active_sp = st_r.interrupt_stack_pointer;
			end
		endcase

		// Read data stands one cycle only; a late sample sees zero
		if (reg_rd) begin
			unique case (reg_addr)
				psc_pkg::OFS_STATUS: begin
					st_nxt.rdata = {16'h0, st_r.sw};
				end
				psc_pkg::OFS_STATE: begin
					st_nxt.rdata = {24'h0, 2'h0, st_r.stopped, st_r.state};
				end
				psc_pkg::OFS_USP: begin
					st_nxt.rdata = st_r.user_stack_pointer;
				end
				psc_pkg::OFS_ISP: begin
					st_nxt.rdata = st_r.interrupt_stack_pointer;
				end
				psc_pkg::OFS_MSP: begin
					st_nxt.rdata = st_r.master_stack_pointer;
				end
				default: begin
					st_nxt.rdata = 32'h0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			st_r <= psc_pkg::REGS_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata = st_r.rdata;
	assign status_word = st_r.sw;
	assign proc_state = st_r.state;
	assign stopped = st_r.stopped;
	assign access_space_code = st_r.fc;
	assign access_valid = st_r.fc_valid;
	assign sp_select = st_r.sp_sel;
	assign active_stack_pointer = st_r.active_sp;
	assign push_valid = st_r.push_valid;
	assign push_status_word = st_r.saved_sw;
	assign priv_trap = st_r.priv_trap;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_entry;
		is_normal && exc_event;
	endsequence
	sequence s_entered;
		(st_r.state == psc_pkg::PSC_ST_STACK) && sup && push_valid;
	endsequence
	sequence s_walk;
		(st_r.state == psc_pkg::PSC_ST_STACK) && !fault && stack_done ##1
		(st_r.state == psc_pkg::PSC_ST_VECTOR) && !fault && vector_done ##1
		(st_r.state == psc_pkg::PSC_ST_FILL) && !fault && handler_start;
	endsequence

	AST_ONE_STATE: assert property ($onehot(st_r.state)) else $error("state not one-hot");
	AST_ENTRY: assert property (s_entry |=> s_entered) else $error("bad exception entry");
	AST_PUSH_OLD: assert property (s_entry |=> push_status_word == $past(st_r.sw))
		else $error("pushed word differs");
	AST_WALK_END: assert property (s_walk |=> is_normal) else $error("exception did not finish");
	AST_HALT_FAULT: assert property (in_exc && fault |=> st_r.state == psc_pkg::PSC_ST_HALT)
		else $error("fault in exception did not halt");
	AST_HALT_KEEP: assert property (st_r.state == psc_pkg::PSC_ST_HALT |=> st_r.state == psc_pkg::PSC_ST_HALT)
		else $error("left halt without reset");
	AST_IRQ_M: assert property (is_normal && irq_ack |=> !master ##0 push_status_word[psc_pkg::M_BIT] ==
		$past(master)) else $error("interrupt master bit");
	AST_M_CAUSE: assert property ($changed(master) |-> $past(!resetn) || $past(irq_ack && is_normal) ||
		$past(op_ok && (op_kind <= psc_pkg::OP_RETURN))) else $error("master bit changed unexpectedly");
	AST_TRAP: assert property (user_violation |=> priv_trap && sup ##1 !priv_trap)
		else $error("privileged op not trapped");
	AST_FC_EXC: assert property (bus_req && in_exc && !bus_cpu_space |=> access_valid && access_space_code[2])
		else $error("exception cycle not supervisor");
	AST_FC_USER: assert property (bus_req && !sup && is_normal && !st_r.stopped && !bus_cpu_space |=>
		access_valid && access_space_code == ($past(bus_program) ? psc_pkg::FC_USER_PROG :
		psc_pkg::FC_USER_DATA)) else $error("user code wrong");
	AST_STOP_QUIET: assert property (st_r.stopped |=> !access_valid) else $error("bus cycle while stopped");
	AST_SP_SEL: assert property (sup && master |=> sp_select == psc_pkg::SEL_MASTER ##1
		active_stack_pointer == $past(st_r.master_stack_pointer)) else $error("master stack not used");
	AST_SP_INT: assert property (sup && !master |=> sp_select == psc_pkg::SEL_INTERRUPT)
		else $error("interrupt stack not used");
	AST_RESET: assert property (@(posedge clock) disable iff (1'b0) !resetn |=> sup && !master && is_normal)
		else $error("reset state wrong");

	// ------------------------------------------------------------
	// Operation, bus and stack checks
	// ------------------------------------------------------------
	sequence s_move_take;
		op_ok && ((op_kind == psc_pkg::OP_MOVE) || (op_kind == psc_pkg::OP_RETURN));
	endsequence
	sequence s_stop_take;
		op_ok && (op_kind == psc_pkg::OP_STOP);
	endsequence
	sequence s_irq_take;
		is_normal && irq_ack;
	endsequence

	AST_OP_MOVE: assert property (s_move_take |=> status_word == $past(op_data))
		else $error("status word not loaded");
	AST_STOP_SET: assert property (s_stop_take |=> stopped && is_normal) else $error("stop not taken");
	AST_STOP_WAKE: assert property (st_r.stopped && exc_event |=> !stopped && (st_r.state == psc_pkg::PSC_ST_STACK))
		else $error("event did not end stop");
	AST_IRQ_PUSH: assert property (s_irq_take |=> push_valid && !master) else $error("interrupt entry");

	// Stopped and halted run no cycles, so both are left out of the code checks
	AST_FC_SUP: assert property (bus_req && sup && !st_r.stopped && (st_r.state != psc_pkg::PSC_ST_HALT) &&
		!bus_cpu_space |=> access_valid && access_space_code == ($past(bus_program) ? psc_pkg::FC_SUPER_PROG :
		psc_pkg::FC_SUPER_DATA)) else $error("supervisor code wrong");
	AST_FC_CPU: assert property (bus_req && bus_cpu_space && !st_r.stopped && (st_r.state != psc_pkg::PSC_ST_HALT) |=>
		access_valid && access_space_code == psc_pkg::FC_CPU_SPACE) else $error("cpu space code wrong");
	AST_FC_LEGAL: assert property (access_valid |-> (access_space_code == psc_pkg::FC_USER_DATA) ||
		(access_space_code == psc_pkg::FC_USER_PROG) || (access_space_code == psc_pkg::FC_SUPER_DATA) ||
		(access_space_code == psc_pkg::FC_SUPER_PROG) || (access_space_code == psc_pkg::FC_CPU_SPACE))
		else $error("reserved code driven");
	AST_HALT_QUIET: assert property (st_r.state == psc_pkg::PSC_ST_HALT |=> !access_valid)
		else $error("bus cycle while halted");

	AST_SP_USER: assert property (!sup && !in_exc |=> sp_select == psc_pkg::SEL_USER)
		else $error("user stack not used");
	AST_EXC_SUP: assert property (in_exc |-> sup) else $error("exception below supervisor");
	AST_SW_HOLD: assert property (!is_normal |=> $stable(status_word)) else $error("status word moved");
	AST_PRIV_SUP: assert property (sup && op_valid && is_normal && !st_r.stopped && !exc_event |=>
		!priv_trap && is_normal) else $error("supervisor op trapped");
	AST_TRAP_PUSH: assert property (priv_trap |-> push_valid) else $error("trap without entry");
endmodule

// [inc/psc_pkg.sv]
package psc_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int SW_W = 16;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int S_BIT = 13;
	localparam int M_BIT = 12;
	localparam logic [15:0] SW_RESET = 16'h2000;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_STATE = 8'h04;
	localparam logic [7:0] OFS_USP = 8'h08;
	localparam logic [7:0] OFS_ISP = 8'h0c;
	localparam logic [7:0] OFS_MSP = 8'h10;
	// ------------------------------------------------------------
	// Access space codes
	// ------------------------------------------------------------
	localparam logic [2:0] FC_USER_DATA = 3'h1;
	localparam logic [2:0] FC_USER_PROG = 3'h2;
	localparam logic [2:0] FC_SUPER_DATA = 3'h5;
	localparam logic [2:0] FC_SUPER_PROG = 3'h6;
	localparam logic [2:0] FC_CPU_SPACE = 3'h7;
	// ------------------------------------------------------------
	// Stack pointer selection
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_USER = 2'h0;
	localparam logic [1:0] SEL_INTERRUPT = 2'h1;
	localparam logic [1:0] SEL_MASTER = 2'h2;
	// ------------------------------------------------------------
	// Operation kinds from the sequencer
	// ------------------------------------------------------------
	localparam logic [2:0] OP_MOVE = 3'h0;
	localparam logic [2:0] OP_AND = 3'h1;
	localparam logic [2:0] OP_XOR = 3'h2;
	localparam logic [2:0] OP_OR = 3'h3;
	localparam logic [2:0] OP_RETURN = 3'h4;
	localparam logic [2:0] OP_STOP = 3'h5;
	localparam logic [2:0] OP_PRIV = 3'h6;
	localparam logic [2:0] OP_PLAIN = 3'h7;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		PSC_ST_NORMAL = 5'h01,
		PSC_ST_STACK = 5'h02,
		PSC_ST_VECTOR = 5'h04,
		PSC_ST_FILL = 5'h08,
		PSC_ST_HALT = 5'h10
	} psc_state_e;
	typedef struct packed {
		psc_state_e state;
		logic stopped;
		logic [15:0] sw;
		logic [31:0] user_stack_pointer;
		logic [31:0] interrupt_stack_pointer;
		logic [31:0] master_stack_pointer;
		logic [15:0] saved_sw;
		logic push_valid;
		logic priv_trap;
		logic [2:0] fc;
		logic fc_valid;
		logic [1:0] sp_sel;
		logic [31:0] active_sp;
		logic [31:0] rdata;
	} psc_regs_s;
	localparam psc_regs_s REGS_RESET = '{
		state: PSC_ST_NORMAL, stopped: 1'b0, sw: SW_RESET, user_stack_pointer: 32'h0, interrupt_stack_pointer: 32'h0, master_stack_pointer: 32'h0,
		saved_sw: 16'h0, push_valid: 1'b0, priv_trap: 1'b0, fc: 3'h0, fc_valid: 1'b0,
		sp_sel: SEL_INTERRUPT, active_sp: 32'h0, rdata: 32'h0};
endpackage

// [testbench/psc_bus_model.sv]
`timescale 1ns/1ps
module psc_bus_model (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [2:0] access_space_code,
	input wire logic access_valid,
	input wire logic fault_req,
	output logic bus_error,
	output logic [7:0] bad_cnt
);
	// ------------------------------------------------------------
	// Fault reply and code watch
	// ------------------------------------------------------------
	// Faults answer one cycle late, as a slow slave would
	always_ff @(posedge clock) begin
		if (!resetn) begin
			bus_error <= 1'b0;
			bad_cnt <= 8'h00;
		end else begin
			bus_error <= fault_req;
			if (access_valid && (access_space_code == 3'h0 || access_space_code == 3'h3 ||
				access_space_code == 3'h4)) begin
				bad_cnt <= bad_cnt + 8'h01;
			end
		end
	end
endmodule

// [testbench/test_privilege_state_control.sv]
`timescale 1ns/1ps
module test_privilege_state_control;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic op_valid = 1'b0;
	logic [2:0] op_kind = 3'h7;
	logic [15:0] op_data = 16'h0;
	logic [7:0] ev = 8'h00;
	logic bus_req = 1'b0;
	logic bus_program = 1'b0;
	logic bus_cpu_space = 1'b0;
	logic sp_wr = 1'b0;
	logic fault_req = 1'b0;
	logic rd_d = 1'b0;
	logic [31:0] sp_wdata = 32'h0;
	logic [31:0] reg_rdata, active_stack_pointer, r;
	logic [15:0] status_word, push_status_word, sw, d;
	logic [4:0] proc_state;
	logic stopped, access_valid, push_valid, priv_trap, bus_error;
	logic [2:0] access_space_code;
	logic [1:0] sp_select;
	logic [7:0] bad_cnt;
	logic [31:0] exp_rd[$];
	logic [2:0] exp_fc[$];
	int error_cnt = 0;
	int samples_checked = 0;
	int cycles = 0;
	psc_top uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid), .op_kind(op_kind), .op_data(op_data),
		.irq_ack(ev[0]), .trace_event(ev[1]), .trap_event(ev[2]), .other_exception(ev[3]), .bus_error(bus_error),
		.address_error(ev[4]), .stack_done(ev[5]), .vector_done(ev[6]), .handler_start(ev[7]), .bus_req(bus_req),
		.bus_program(bus_program), .bus_cpu_space(bus_cpu_space), .sp_wr(sp_wr), .sp_wdata(sp_wdata),
		.status_word(status_word), .proc_state(proc_state), .stopped(stopped), .access_space_code(access_space_code),
		.access_valid(access_valid), .sp_select(sp_select), .active_stack_pointer(active_stack_pointer),
		.push_valid(push_valid), .push_status_word(push_status_word), .priv_trap(priv_trap));
	psc_bus_model partner (.clock(clock), .resetn(resetn), .access_space_code(access_space_code),
		.access_valid(access_valid), .fault_req(fault_req), .bus_error(bus_error), .bad_cnt(bad_cnt));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] v);
		exp_rd.push_back(v);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask
	task op(input logic [2:0] k, input logic [15:0] v);
		@(posedge clock);
		op_valid <= 1'b1;
		op_kind <= k;
		op_data <= v;
		@(posedge clock);
		op_valid <= 1'b0;
		#1;
	endtask
	task fire(input int i);
		@(posedge clock);
		ev[i] <= 1'b1;
		@(posedge clock);
		ev <= 8'h00;
		#1;
	endtask
	task bus(input logic p, input logic c, input logic [2:0] e, input logic ans);
		if (ans) begin
			exp_fc.push_back(e);
		end
		@(posedge clock);
		bus_req <= 1'b1;
		bus_program <= p;
		bus_cpu_space <= c;
		@(posedge clock);
		bus_req <= 1'b0;
		#1;
	endtask
	// Handler start must be the last step; the state stays exceptional until then
	task walk;
		fire(5);
		check(proc_state, 5'h04, "proc_state");
		fire(6);
		check(proc_state, 5'h08, "proc_state");
		fire(7);
		check(proc_state, 5'h01, "proc_state");
	endtask
	// ------------------------------------------------------------
	// Clock, monitor and timeout
	// ------------------------------------------------------------
	initial begin
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		rd_d <= reg_rd;
		cycles++;
		if (rd_d) begin
			check(reg_rdata, exp_rd.pop_front(), "reg_rdata");
		end
		if (access_valid === 1'b1) begin
			if (exp_fc.size() == 0) begin
				check(1'b1, 1'b0, "unexpected access");
			end else begin
				check(access_space_code, exp_fc.pop_front(), "access_space_code");
			end
		end
		if (cycles == 6000) begin
			error_cnt++;
			print_verdict;
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'hca9a8e97));
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		#1;
		check(status_word, psc_pkg::SW_RESET, "status_word");
		check(proc_state, 5'h01, "proc_state");
		check(sp_select, psc_pkg::SEL_INTERRUPT, "sp_select");
		wr(psc_pkg::OFS_STATUS, 32'h0);
		rd(psc_pkg::OFS_STATUS, {16'h0, psc_pkg::SW_RESET});
		rd(8'h20, 32'h0);
		rd(psc_pkg::OFS_STATE, 32'h1);
		for (int i = 0; i < 3; i++) begin
			r = $urandom;
			wr(psc_pkg::OFS_USP + 8'(4 * i), r);
			rd(psc_pkg::OFS_USP + 8'(4 * i), r);
			wr(psc_pkg::OFS_USP + 8'(4 * i), 32'h100 * (i + 1));
		end
		@(posedge clock);
		sp_wr <= 1'b1;
		sp_wdata <= 32'h250;
		@(posedge clock);
		sp_wr <= 1'b0;
		rd(psc_pkg::OFS_ISP, 32'h250);
		check(active_stack_pointer, 32'h250, "active_sp");
		sw = psc_pkg::SW_RESET;
		for (int k = 0; k < 4; k++) begin
			r = $urandom;
			d = (k == 2) ? (r[15:0] & 16'hdfff) : (r[15:0] | 16'h2000);
			op(3'(k), d);
			sw = (k == 0) ? d : (k == 1) ? (sw & d) : (k == 2) ? (sw ^ d) : (sw | d);
			check(status_word, sw, "status_word");
		end
		op(psc_pkg::OP_MOVE, 16'h3000);
		repeat (2) @(posedge clock);
		#1;
		check(sp_select, psc_pkg::SEL_MASTER, "sp_select");
		check(active_stack_pointer, 32'h300, "active_sp");
		op(psc_pkg::OP_PRIV, 16'h0);
		check(priv_trap, 1'b0, "priv_trap");
		check(proc_state, 5'h01, "proc_state");
		bus(1'b1, 1'b0, psc_pkg::FC_SUPER_PROG, 1'b1);
		bus(1'b0, 1'b0, psc_pkg::FC_SUPER_DATA, 1'b1);
		bus(1'b0, 1'b1, psc_pkg::FC_CPU_SPACE, 1'b1);
		fire(0);
		check(proc_state, 5'h02, "proc_state");
		check(push_valid, 1'b1, "push_valid");
		check(push_status_word, 16'h3000, "push_word");
		check(status_word, 16'h2000, "status_word");
		op(psc_pkg::OP_XOR, 16'h2000);
		check(status_word, 16'h2000, "status_word");
		check(sp_select, psc_pkg::SEL_INTERRUPT, "sp_select");
		bus(1'b0, 1'b0, psc_pkg::FC_SUPER_DATA, 1'b1);
		walk;
		op(psc_pkg::OP_RETURN, 16'h3000);
		check(status_word, 16'h3000, "status_word");
		for (int i = 1; i < 4; i++) begin
			op(psc_pkg::OP_MOVE, 16'h0000);
			repeat (2) @(posedge clock);
			#1;
			check(sp_select, psc_pkg::SEL_USER, "sp_select");
			check(active_stack_pointer, 32'h100, "active_sp");
			bus(1'b1, 1'b0, psc_pkg::FC_USER_PROG, 1'b1);
			bus(1'b0, 1'b0, psc_pkg::FC_USER_DATA, 1'b1);
			fire(i);
			check(proc_state, 5'h02, "proc_state");
			check(status_word, 16'h2000, "status_word");
			check(push_status_word, 16'h0000, "push_word");
			walk;
		end
		op(psc_pkg::OP_MOVE, 16'h0000);
		op(psc_pkg::OP_PRIV, 16'h0);
		check(priv_trap, 1'b1, "priv_trap");
		check(proc_state, 5'h02, "proc_state");
		check(status_word, 16'h2000, "status_word");
		walk;
		op(psc_pkg::OP_STOP, 16'h0);
		check(stopped, 1'b1, "stopped");
		bus(1'b0, 1'b0, 3'h0, 1'b0);
		rd(psc_pkg::OFS_STATE, 32'h21);
		fire(1);
		check(stopped, 1'b0, "stopped");
		@(posedge clock);
		fault_req <= 1'b1;
		@(posedge clock);
		fault_req <= 1'b0;
		@(posedge clock);
		#1;
		check(proc_state, 5'h10, "proc_state");
		fire(7);
		fire(0);
		bus(1'b0, 1'b0, 3'h0, 1'b0);
		check(proc_state, 5'h10, "proc_state");
		@(posedge clock);
		resetn <= 1'b0;
		@(posedge clock);
		resetn <= 1'b1;
		#1;
		check(proc_state, 5'h01, "proc_state");
		check(status_word, psc_pkg::SW_RESET, "status_word");
		fire(2);
		fire(4);
		check(proc_state, 5'h10, "proc_state");
		repeat (4) @(posedge clock);
		check(exp_fc.size(), 32'h0, "pending accesses");
		check(bad_cnt, 8'h00, "reserved codes");
		print_verdict;
	end
endmodule
